// ==== hw/sldrv_pkg.sv ====
// package for the serial segment driver: sizes, reset values and timing counts
// assumes one 20 MHz system clock shared by every block that uses it
package sldrv_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int SEG_COUNT = 32;
   localparam int FIFO_DEPTH = 4;
   localparam int BP_DIV_BITS = 8;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 20000000;
   localparam int OSC_FREQ_HZ = 10000;
   localparam int OSC_HALF_CYCLES = CLK_FREQ_HZ / (2 * OSC_FREQ_HZ);
   localparam int DRIVE_LOSS_US = 200;
   localparam int DRIVE_LOSS_CYCLES = (DRIVE_LOSS_US * (CLK_FREQ_HZ / 1000000));
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [SEG_COUNT-1:0] SEG_RESET = 32'h00000000;
   localparam logic [BP_DIV_BITS-1:0] DIV_RESET = 8'h00;
endpackage

// ==== hw/sldrv_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sldrv_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic in_valid, // write request
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic in_ready, // room for one more word
   output logic out_valid, // a word is waiting
   output logic [WIDTH-1:0] out_data, // oldest word
   input wire logic out_ready // reader takes the word
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] count_next;
   logic in_ready_reg;
   wire logic push;
   wire logic pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign push = in_valid && in_ready_reg;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign in_ready = in_ready_reg;
   assign count_next = count_reg + CW'(push) - CW'(pop);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready_reg <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         count_reg <= count_next;
         in_ready_reg <= (count_next != CW'(DEPTH));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ==== hw/sldrv_top.sv ====
// serial-input lcd segment driver: shift register, load latches, backplane
// assumes all pin inputs are already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - each falling shift-clock edge captures serial input, advances the register, updates data out.
// - a one in a stage makes its segment visible, a zero leaves it blank.
// - while load is high the whole register is copied in parallel into the latches.
// - load held high makes the latches transparent so segments follow the register.
// - segment N shows the bit that was at the input N shift pulses earlier.
// - register and latches have thirty-two stages, one per segment.
// - an externally driven frame input is sensed and passed in phase to the backplane.
// - when oscillating, backplane and segments run at oscillator frequency over 256.
// - data out may feed the next device's data in, or devices may be loaded in parallel.
module sldrv_top #(
   parameter int SEGS = sldrv_pkg::SEG_COUNT,
   parameter int OSC_HALF = sldrv_pkg::OSC_HALF_CYCLES,
   parameter int DRIVE_LOSS = sldrv_pkg::DRIVE_LOSS_CYCLES
) (
   input wire logic clk_sys, // system clock
   input wire logic srst, // synchronous reset
   input wire logic shift_clk, // host shift clock
   input wire logic serial_in, // serial segment data
   input wire logic load_in, // latch load, level
   output logic serial_out, // last stage, cascade out
   output logic shift_ready, // buffer has room for a bit
   input wire logic frame_osc_input, // frame pin level
   output logic frame_osc_out, // frame pin drive value
   output logic frame_osc_oe, // frame pin drive enable
   output logic backplane_out, // backplane drive
   output logic [SEGS-1:0] segment_output // segment drives
);
   // ----------------------------------------------------------------
   // shift capture and buffering
   // ----------------------------------------------------------------
   logic shift_clk_prev_reg;
   logic load_prev_reg;
   logic [SEGS-1:0] sr_reg;
   logic [SEGS-1:0] latch_reg;
   logic [SEGS-1:0] latch_next;
   logic [SEGS-1:0] seg_reg;
   logic sdo_reg;
   wire logic clk_fall;
   wire logic load_rise;
   wire logic buf_valid;
   wire logic buf_data;
   wire logic pop;

   // we sample data on the host's falling edge only; it keeps the pin still there
   assign clk_fall = shift_clk_prev_reg && !shift_clk;
   assign load_rise = load_in && !load_prev_reg;
   // drain pauses on the first load cycle so the latch copy sees a settled register
   assign pop = buf_valid && !load_rise;

   sldrv_fifo #(
      .WIDTH(1),
      .DEPTH(sldrv_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .in_valid(clk_fall),
      .in_data(serial_in),
      .in_ready(shift_ready),
      .out_valid(buf_valid),
      .out_data(buf_data),
      .out_ready(!load_rise)
   );

   // ----------------------------------------------------------------
   // shift register and latches
   // ----------------------------------------------------------------
   // stage 0 is segment 1, so segment N holds the bit shifted in N pulses ago
   assign latch_next = load_in ? sr_reg : latch_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         shift_clk_prev_reg <= 1'b1;
         load_prev_reg <= 1'b0;
         sr_reg <= sldrv_pkg::SEG_RESET;
         latch_reg <= sldrv_pkg::SEG_RESET;
         sdo_reg <= 1'b0;
      end else begin
         shift_clk_prev_reg <= shift_clk;
         load_prev_reg <= load_in;
         if (pop) begin
            sr_reg <= {sr_reg[SEGS-2:0], buf_data};
            sdo_reg <= sr_reg[SEGS-2];
         end
         latch_reg <= latch_next;
      end
   end

   // ----------------------------------------------------------------
   // frame source: internal oscillator or external drive
   // ----------------------------------------------------------------
   localparam int OCW = $clog2(OSC_HALF + 1);
   localparam int LCW = $clog2(DRIVE_LOSS + 1);
   logic [OCW-1:0] osc_cnt_reg;
   logic osc_reg;
   logic oe_reg;
   logic driven_reg;
   logic [LCW-1:0] loss_cnt_reg;
   logic frame_prev_reg;
   logic [sldrv_pkg::BP_DIV_BITS-1:0] div_reg;
   logic bp_reg;
   wire logic osc_wrap;
   wire logic osc_rise;
   wire logic contend;
   wire logic frame_edge;

   assign osc_wrap = (osc_cnt_reg == OCW'(OSC_HALF - 1));
   assign osc_rise = osc_wrap && !osc_reg && !driven_reg;
   // a foreign driver shows as the pin disagreeing with what we drive
   assign contend = oe_reg && (frame_osc_input != osc_reg);
   assign frame_edge = frame_osc_input != frame_prev_reg;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         osc_cnt_reg <= '0;
         osc_reg <= 1'b0;
         oe_reg <= 1'b1;
         driven_reg <= 1'b0;
         loss_cnt_reg <= '0;
         frame_prev_reg <= 1'b0;
         div_reg <= sldrv_pkg::DIV_RESET;
         bp_reg <= 1'b0;
      end else begin
         frame_prev_reg <= frame_osc_input;
         osc_cnt_reg <= osc_wrap ? '0 : osc_cnt_reg + 1'b1;
         if (osc_wrap) begin
            osc_reg <= !osc_reg;
         end
         if (contend) begin
            driven_reg <= 1'b1;
            oe_reg <= 1'b0;
            loss_cnt_reg <= '0;
         end else if (driven_reg) begin
            // a driver that stops toggling is dropped and we oscillate again
            if (frame_edge) begin
               loss_cnt_reg <= '0;
            end else if (loss_cnt_reg == LCW'(DRIVE_LOSS - 1)) begin
               driven_reg <= 1'b0;
               oe_reg <= 1'b1;
               loss_cnt_reg <= '0;
            end else begin
               loss_cnt_reg <= loss_cnt_reg + 1'b1;
            end
         end
         if (osc_rise) begin
            div_reg <= div_reg + 1'b1;
         end
         if (driven_reg) begin
            bp_reg <= frame_osc_input;
         end else begin
            bp_reg <= div_reg[sldrv_pkg::BP_DIV_BITS-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // segment drive
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         seg_reg <= sldrv_pkg::SEG_RESET;
      end else begin
         seg_reg <= latch_reg ^ {SEGS{bp_reg}};
      end
   end

   assign segment_output = seg_reg;
   assign backplane_out = bp_reg;
   assign serial_out = sdo_reg;
   assign frame_osc_out = osc_reg;
   assign frame_osc_oe = oe_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_fall_taken;
      shift_clk_prev_reg && !shift_clk && shift_ready;
   endsequence

   a_fall_buffered: assert property (s_fall_taken |=> buf_valid)
      else $error("falling shift clock not buffered");
   a_shift_advance: assert property (pop |=> sr_reg == {$past(sr_reg[SEGS-2:0]), $past(buf_data)})
      else $error("shift register did not advance by one");
   a_sdo_update: assert property (pop |=> serial_out == $past(sr_reg[SEGS-2]))
      else $error("serial out not updated on shift");
   a_latch_load: assert property (load_in |=> latch_reg == $past(sr_reg))
      else $error("latches not loaded while load high");
   a_latch_hold: assert property (!load_in |=> $stable(latch_reg))
      else $error("latches changed while load low");
   a_transparent_follow: assert property (load_in [*3] |-> latch_reg == $past(sr_reg))
      else $error("latches not transparent under steady load");
   a_seg_polarity: assert property (##1 segment_output == ($past(latch_reg) ^ {SEGS{$past(bp_reg)}}))
      else $error("segment polarity wrong against backplane");
   a_driven_phase: assert property (driven_reg |=> backplane_out == $past(frame_osc_input))
      else $error("backplane not in phase with driven frame input");
   a_driven_release: assert property (contend |=> driven_reg && !frame_osc_oe)
      else $error("frame pin not released on external drive");
   a_div_256: assert property (osc_rise && div_reg == 8'hFF |=> ##1 !driven_reg |-> backplane_out == 1'b0)
      else $error("backplane not divided by 256");
   a_stall_hold: assert property (load_rise |=> $stable(sr_reg))
      else $error("register moved during load stall");
   a_osc_toggle: assert property (osc_wrap |=> frame_osc_out != $past(frame_osc_out))
      else $error("oscillator did not toggle at wrap");
   a_div_frozen: assert property (driven_reg |=> $stable(div_reg))
      else $error("divider ran while frame driven from outside");
   // a driver that went quiet must hand the pin back, or the backplane stops
   a_drive_drop: assert property (driven_reg && !contend && !frame_edge
      && loss_cnt_reg == LCW'(DRIVE_LOSS - 1) |=> frame_osc_oe && !driven_reg)
      else $error("frame pin not reclaimed after drive loss");
endmodule
`default_nettype wire

// ==== tb/sldrv_host_model.sv ====
// host model: drives shift clock, serial data and load of the segment driver
// assumes every change lands on a falling edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module sldrv_host_model (
   input wire logic clk_sys, // system clock
   input wire logic shift_ready, // driver can take a bit
   output logic shift_clk, // host shift clock
   output logic serial_in, // serial segment data
   output logic load_in, // latch load
   output logic stuck // ready never came
);
   initial begin
      shift_clk = 1'b1;
      serial_in = 1'b0;
      load_in = 1'b0;
      stuck = 1'b0;
   end
   // ----------------------------------------------------------------
   // transfers
   // ----------------------------------------------------------------
   // data settles a cycle ahead of the fall so the two never move together
   task automatic shift_bit(input logic b);
      int n;
      n = 0;
      @(negedge clk_sys);
      serial_in = b;
      while (shift_ready !== 1'b1 && n < 50) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 50) stuck = 1'b1;
      @(negedge clk_sys);
      shift_clk = 1'b0;
      @(negedge clk_sys);
      shift_clk = 1'b1;
      serial_in = ~b; // released data must not look like the last bit
   endtask
   task automatic set_load(input logic v);
      @(negedge clk_sys);
      load_in = v;
   endtask
endmodule
`default_nettype wire

// ==== tb/sldrv_top_tb.sv ====
// testbench of the serial segment driver with a host model on its input side
// assumes the shortened oscillator and drive-loss counts set below
`timescale 1ns/1ps
`default_nettype none
module sldrv_top_tb;
   localparam int OSC_HALF = 2;
   localparam int DRIVE_LOSS = 20;
   localparam logic [31:0] PAT = 32'h9AC3F01E;
   logic clk_sys, srst, shift_clk, serial_in, load_in, serial_out, shift_ready, stuck;
   logic frame_osc_out, frame_osc_oe, backplane_out, ext_en, ext_val, bp_d, pin_d;
   logic [31:0] segment_output, exp_sr, exp_latch;
   wire frame_pin;
   int num_errors, compares;
   // an outside drive overpowers ours; a pin nobody drives sits low
   assign frame_pin = ext_en ? ext_val : (frame_osc_oe ? frame_osc_out : 1'b0);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      bp_d <= backplane_out;
      pin_d <= frame_pin;
   end
   sldrv_top #(.OSC_HALF(OSC_HALF), .DRIVE_LOSS(DRIVE_LOSS)) u_sldrv_top (
      .clk_sys(clk_sys), .srst(srst), .shift_clk(shift_clk), .serial_in(serial_in),
      .load_in(load_in), .serial_out(serial_out), .shift_ready(shift_ready),
      .frame_osc_input(frame_pin), .frame_osc_out(frame_osc_out),
      .frame_osc_oe(frame_osc_oe), .backplane_out(backplane_out),
      .segment_output(segment_output));
   sldrv_host_model u_sldrv_host_model (.clk_sys(clk_sys), .shift_ready(shift_ready),
      .shift_clk(shift_clk), .serial_in(serial_in), .load_in(load_in), .stuck(stuck));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("num_errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic tb_shift(input logic b);
      u_sldrv_host_model.shift_bit(b);
      exp_sr = {exp_sr[30:0], b};
   endtask
   // covers buffer drain, a load-rise stall, latch and segment register
   task automatic settle();
      repeat (6) @(negedge clk_sys);
   endtask
   task automatic wait_rise(output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (!(backplane_out === 1'b1 && bp_d === 1'b0) && n < 3000);
      if (n >= 3000) begin
         num_errors++;
         complete_run();
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_shift_load();
      exp_latch = 32'h00000000;
      for (int i = 31; i >= 0; i--) tb_shift(PAT[i]);
      settle();
      check("held latches", exp_latch ^ {32{bp_d}}, segment_output);
      u_sldrv_host_model.set_load(1'b1);
      u_sldrv_host_model.set_load(1'b0);
      exp_latch = exp_sr;
      settle();
      check("loaded segments", exp_latch ^ {32{bp_d}}, segment_output);
      check("cascade out", {31'h0, exp_sr[31]}, {31'h0, serial_out});
   endtask
   task automatic t_transparent();
      u_sldrv_host_model.set_load(1'b1);
      for (int i = 0; i < 3; i++) begin
         tb_shift(i[0]);
         settle();
         check("transparent", exp_sr ^ {32{bp_d}}, segment_output);
      end
      u_sldrv_host_model.set_load(1'b0);
   endtask
   task automatic t_ext_frame();
      ext_en = 1'b1;
      for (int i = 0; i < 70; i++) begin
         @(negedge clk_sys);
         if (i % 7 == 0) ext_val = ~ext_val;
         if (i > 8) check("frame follow", {31'h0, pin_d}, {30'h0, frame_osc_oe, backplane_out});
      end
      ext_en = 1'b0;
      repeat (DRIVE_LOSS + 10) @(negedge clk_sys);
      check("drive back", 32'h00000001, {31'h0, frame_osc_oe});
   endtask
   task automatic t_osc_rate();
      int n;
      int toggles;
      logic last;
      wait_rise(n);
      wait_rise(n);
      check("backplane period", 32'(256 * 2 * OSC_HALF), 32'(n));
      toggles = 0;
      last = frame_osc_out;
      repeat (40) begin
         @(negedge clk_sys);
         if (frame_osc_out !== last) toggles++;
         last = frame_osc_out;
      end
      check("osc toggles", 32'(40 / OSC_HALF), 32'(toggles));
   endtask
   initial begin
      srst = 1'b1;
      ext_en = 1'b0;
      ext_val = 1'b0;
      exp_sr = 32'h00000000;
      num_errors = 0;
      compares = 0;
      repeat (6) @(negedge clk_sys);
      srst = 1'b0;
      check("reset segments", 32'h00000000, segment_output);
      check("reset outputs", 32'h00000003, {27'h0, frame_osc_out, backplane_out, serial_out,
         shift_ready, frame_osc_oe});
      t_shift_load();
      t_transparent();
      t_ext_frame();
      t_osc_rate();
      check("host stall", 32'h00000000, {31'h0, stuck});
      complete_run();
   end
endmodule
`default_nettype wire
